// file: verilog/hsm_pkg.sv
package hsm_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] HSM_CMD_CLEAR_FAULTS   = 8'h03;
  localparam logic [7:0] HSM_CMD_MISC_FAULT     = 8'h7f;
  localparam logic [7:0] HSM_CMD_VENDOR_FAULT   = 8'h80;
  localparam logic [7:0] HSM_CMD_VIN_READ       = 8'h88;
  localparam logic [7:0] HSM_CMD_VOUT_READ      = 8'h8b;
  localparam logic [7:0] HSM_CMD_IOUT_READ      = 8'h8c;
  localparam logic [7:0] HSM_CMD_TEMP_READ      = 8'h8d;
  localparam logic [7:0] HSM_CMD_PIN_READ       = 8'h97;
  localparam logic [7:0] HSM_CMD_PROTO_REV      = 8'h98;
  localparam logic [7:0] HSM_CMD_MAKER_STRING   = 8'h99;
  localparam logic [7:0] HSM_CMD_HW_REV         = 8'h9b;
  localparam logic [7:0] HSM_CMD_PART_ID        = 8'had;
  localparam logic [7:0] HSM_CMD_PART_REV       = 8'hae;
  localparam logic [7:0] HSM_CMD_TOOL_SCRATCH   = 8'hb0;
  localparam logic [7:0] HSM_CMD_OEM_SCRATCH    = 8'hb2;
  localparam logic [7:0] HSM_CMD_FAULT_PIN_OPT  = 8'hd2;
  localparam logic [7:0] HSM_CMD_FET_BAD_RESP   = 8'hd6;
  localparam logic [7:0] HSM_CMD_OVERPOWER_RESP = 8'hd7;
  localparam logic [7:0] HSM_CMD_ADC_MODE       = 8'hd8;
  localparam logic [7:0] HSM_CMD_ADC_AVG        = 8'hd9;
  localparam logic [7:0] HSM_CMD_TICK_TIMER     = 8'hdc;
  localparam logic [7:0] HSM_CMD_SYS_STATUS     = 8'he0;
  localparam logic [7:0] HSM_CMD_SYS_WARNING    = 8'he1;
  localparam logic [7:0] HSM_CMD_BUS_FAIL       = 8'he2;
  localparam logic [7:0] HSM_CMD_PAD_LIVE       = 8'he5;
  localparam logic [7:0] HSM_CMD_SPECIAL_ID     = 8'he7;
  localparam logic [7:0] HSM_CMD_FAMILY_STATUS  = 8'hef;
  localparam logic [7:0] HSM_CMD_SD_REASON      = 8'hf1;
  localparam logic [7:0] HSM_CMD_LIMIT_RANGE    = 8'hf2;
  localparam logic [7:0] HSM_CMD_MISC_CONFIG    = 8'hf3;
  localparam logic [7:0] HSM_CMD_PIN_POLARITY   = 8'hf4;
  localparam logic [7:0] HSM_CMD_LOW_OUT_SEL    = 8'hf5;
  localparam logic [7:0] HSM_CMD_HIGH_OUT_SEL   = 8'hf6;
  localparam logic [7:0] HSM_CMD_IN_SEL         = 8'hf7;

  // ----------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  HSM_RST_BYTE_ZERO      = 8'h00;
  localparam logic [15:0] HSM_RST_WORD_ZERO      = 16'h0000;
  localparam logic [7:0]  HSM_PROTO_REV_1P3      = 8'h33;
  localparam logic [7:0]  HSM_RST_FET_BAD_RESP   = 8'h41;
  localparam logic [15:0] HSM_RST_OVERPOWER_RESP = 16'hffe0;
  localparam logic [7:0]  HSM_RST_ADC_MODE       = 8'h01;
  localparam logic [7:0]  HSM_RST_ADC_AVG        = 8'h85;
  localparam logic [15:0] HSM_RST_LIMIT_RANGE    = 16'h5572;
  localparam logic [15:0] HSM_RST_MISC_CONFIG    = 16'h00ef;
  localparam logic [15:0] HSM_RST_PIN_POLARITY   = 16'h009b;
  localparam logic [15:0] HSM_RST_LOW_OUT_SEL    = 16'h5f43;
  localparam logic [15:0] HSM_RST_HIGH_OUT_SEL   = 16'h8207;
  localparam logic [15:0] HSM_RST_IN_SEL         = 16'h0005;
  localparam logic [47:0] HSM_RST_TICK           = 48'h000000000000;
  localparam logic [47:0] HSM_TICK_STEP          = 48'h000000000001;

  // averaged readbacks are shown while this bit of the averaging byte is set
  localparam int unsigned HSM_AVG_SHOW_BIT = 7;

  // ----------------------------------------------------------------
  // widths and answer lengths in bytes
  // ----------------------------------------------------------------
  localparam int unsigned HSM_DATA_W  = 48;
  localparam int unsigned HSM_NPINS   = 8;
  localparam logic [2:0]  HSM_LEN_NONE  = 3'h0;
  localparam logic [2:0]  HSM_LEN_BYTE  = 3'h1;
  localparam logic [2:0]  HSM_LEN_WORD  = 3'h2;
  localparam logic [2:0]  HSM_LEN_MAKER = 3'h3;
  localparam logic [2:0]  HSM_LEN_TICK  = 3'h6;

  typedef logic [HSM_DATA_W-1:0] hsm_data_t;

endpackage : hsm_pkg

// file: verilog/hsm_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

interface hsm_tick_if;
  import hsm_pkg::*;

  logic      load;
  hsm_data_t load_val;
  hsm_data_t value;

  modport timer (input load, input load_val, output value);
  modport user  (output load, output load_val, input value);

endinterface : hsm_tick_if

`default_nettype wire

// file: verilog/hsm_tick_timer.sv
`timescale 1ns/1ps
`default_nettype none

module hsm_tick_timer
  import hsm_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  // tick source
  input  wire logic tick_i,
  // command side
  hsm_tick_if.timer tk
);
  import hsm_pkg::*;

  hsm_data_t count_reg;

  // a write in the same cycle as a tick wins, so the set time is exact
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg <= HSM_RST_TICK;
    end else if (ce_i) begin
      if (tk.load) begin
        count_reg <= tk.load_val;
      end else if (tick_i) begin
        count_reg <= count_reg + HSM_TICK_STEP;
      end
    end
  end

  assign tk.value = count_reg;

endmodule : hsm_tick_timer

`default_nettype wire

// file: verilog/hsm_command_bank.sv
`timescale 1ns/1ps
`default_nettype none

module hsm_command_bank
  import hsm_pkg::*;
#(
  // identification values, all arbitrary
  parameter logic [23:0] MAKER_STRING = 24'h414243,
  parameter logic [7:0]  HW_REVISION  = 8'h01,
  parameter logic [7:0]  PART_ID      = 8'h41,
  parameter logic [7:0]  PART_REV     = 8'h31,
  parameter logic [15:0] SPECIAL_ID   = 16'h1234
)(
  // clock, reset, enable
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 ce_i,
  // command port from the serial engine
  input  wire logic [7:0]           cmd_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  input  wire logic                 send_i,
  input  wire hsm_pkg::hsm_data_t   wdata_i,
  output logic                      rvalid_o,
  output hsm_pkg::hsm_data_t        rdata_o,
  output logic [2:0]                rlen_o,
  // measurements, instantaneous and averaged; temperature instantaneous only
  input  wire logic [15:0]          vin_inst_i,
  input  wire logic [15:0]          vin_avg_i,
  input  wire logic [15:0]          vout_inst_i,
  input  wire logic [15:0]          vout_avg_i,
  input  wire logic [15:0]          iout_inst_i,
  input  wire logic [15:0]          iout_avg_i,
  input  wire logic [15:0]          pin_inst_i,
  input  wire logic [15:0]          pin_avg_i,
  input  wire logic [15:0]          temp_i,
  // status events and live state
  input  wire logic [7:0]           misc_fault_set_i,
  input  wire logic [7:0]           vendor_fault_set_i,
  input  wire logic [15:0]          sys_status_set_i,
  input  wire logic [15:0]          sys_warning_set_i,
  input  wire logic [7:0]           bus_fail_set_i,
  input  wire logic                 shutdown_i,
  input  wire logic [7:0]           shutdown_cause_i,
  input  wire logic [15:0]          pad_live_i,
  input  wire logic [7:0]           family_status_i,
  input  wire logic                 tick_i,
  // settings to the rest of the device
  output logic [7:0]                fault_pin_option_o,
  output logic [7:0]                fet_bad_response_o,
  output logic [15:0]               overpower_response_o,
  output logic [7:0]                adc_mode_o,
  output logic [7:0]                adc_avg_o,
  output logic [15:0]               limit_range_o,
  output logic [15:0]               misc_config_o,
  output logic [15:0]               pin_polarity_o,
  output logic [15:0]               low_out_sel_o,
  output logic [15:0]               high_out_sel_o,
  output logic [15:0]               in_sel_o,
  output logic [HSM_NPINS-1:0]      pad_in_o
);
  import hsm_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic        clr_all;
  logic [7:0]  w8;
  logic [15:0] w16;
  assign clr_all = send_i && (cmd_i == HSM_CMD_CLEAR_FAULTS);
  assign w8      = wdata_i[7:0];
  assign w16     = wdata_i[15:0];
  function automatic logic wr_hit(input logic [7:0] code);
    wr_hit = wr_i && (cmd_i == code);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // latched status, write one to clear
  // ----------------------------------------------------------------
  // a new event wins over a clear that lands in the same cycle
  logic [7:0]  misc_fault_reg;
  logic [7:0]  vendor_fault_reg;
  logic [15:0] sys_status_reg;
  logic [15:0] sys_warning_reg;
  logic [7:0]  misc_clr;
  logic [7:0]  vendor_clr;
  logic [15:0] status_clr;
  logic [15:0] warning_clr;
  always_comb begin
    misc_clr    = (wr_hit(HSM_CMD_MISC_FAULT)   ? w8  : HSM_RST_BYTE_ZERO) | {8{clr_all}};
    vendor_clr  = (wr_hit(HSM_CMD_VENDOR_FAULT) ? w8  : HSM_RST_BYTE_ZERO) | {8{clr_all}};
    status_clr  = (wr_hit(HSM_CMD_SYS_STATUS)   ? w16 : HSM_RST_WORD_ZERO) | {16{clr_all}};
    warning_clr = (wr_hit(HSM_CMD_SYS_WARNING)  ? w16 : HSM_RST_WORD_ZERO) | {16{clr_all}};
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      misc_fault_reg   <= HSM_RST_BYTE_ZERO;
      vendor_fault_reg <= HSM_RST_BYTE_ZERO;
    end else if (ce_i) begin
      misc_fault_reg   <= (misc_fault_reg & ~misc_clr) | misc_fault_set_i;
      vendor_fault_reg <= (vendor_fault_reg & ~vendor_clr) | vendor_fault_set_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_status_reg  <= HSM_RST_WORD_ZERO;
      sys_warning_reg <= HSM_RST_WORD_ZERO;
    end else if (ce_i) begin
      sys_status_reg  <= (sys_status_reg & ~status_clr) | sys_status_set_i;
      sys_warning_reg <= (sys_warning_reg & ~warning_clr) | sys_warning_set_i;
    end
  end

  // ----------------------------------------------------------------
  // failed-transfer detail and shutdown reason
  // ----------------------------------------------------------------
  logic [7:0] bus_fail_reg;
  logic [7:0] sd_reason_reg;
  // host may write the detail byte; fresh failures still land on top
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_fail_reg <= HSM_RST_BYTE_ZERO;
    end else if (ce_i) begin
      if (clr_all) begin
        bus_fail_reg <= bus_fail_set_i;
      end else if (wr_hit(HSM_CMD_BUS_FAIL)) begin
        bus_fail_reg <= w8 | bus_fail_set_i;
      end else begin
        bus_fail_reg <= bus_fail_reg | bus_fail_set_i;
      end
    end
  end

  // no host write path: the reason only changes on a shutdown or a clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sd_reason_reg <= HSM_RST_BYTE_ZERO;
    end else if (ce_i) begin
      if (shutdown_i) begin
        sd_reason_reg <= shutdown_cause_i;
      end else if (clr_all) begin
        sd_reason_reg <= HSM_RST_BYTE_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration bytes and words
  // ----------------------------------------------------------------
  logic [7:0]  fault_pin_option_reg;
  logic [7:0]  fet_bad_response_reg;
  logic [15:0] overpower_response_reg;
  logic [7:0]  adc_mode_reg;
  logic [7:0]  adc_avg_reg;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_pin_option_reg   <= HSM_RST_BYTE_ZERO;
      fet_bad_response_reg   <= HSM_RST_FET_BAD_RESP;
      overpower_response_reg <= HSM_RST_OVERPOWER_RESP;
    end else if (ce_i) begin
      if (wr_hit(HSM_CMD_FAULT_PIN_OPT)) begin
        fault_pin_option_reg <= w8;
      end
      if (wr_hit(HSM_CMD_FET_BAD_RESP)) begin
        fet_bad_response_reg <= w8;
      end
      if (wr_hit(HSM_CMD_OVERPOWER_RESP)) begin
        overpower_response_reg <= w16;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      adc_mode_reg <= HSM_RST_ADC_MODE;
      adc_avg_reg  <= HSM_RST_ADC_AVG;
    end else if (ce_i) begin
      if (wr_hit(HSM_CMD_ADC_MODE)) begin
        adc_mode_reg <= w8;
      end
      if (wr_hit(HSM_CMD_ADC_AVG)) begin
        adc_avg_reg <= w8;
      end
    end
  end

  logic [15:0] limit_range_reg;
  logic [15:0] misc_config_reg;
  logic [15:0] pin_polarity_reg;
  logic [15:0] low_out_sel_reg;
  logic [15:0] high_out_sel_reg;
  logic [15:0] in_sel_reg;
  logic [15:0] tool_scratch_reg;
  logic [15:0] oem_scratch_reg;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      limit_range_reg  <= HSM_RST_LIMIT_RANGE;
      misc_config_reg  <= HSM_RST_MISC_CONFIG;
      tool_scratch_reg <= HSM_RST_WORD_ZERO;
      oem_scratch_reg  <= HSM_RST_WORD_ZERO;
    end else if (ce_i) begin
      if (wr_hit(HSM_CMD_LIMIT_RANGE)) begin
        limit_range_reg <= w16;
      end
      if (wr_hit(HSM_CMD_MISC_CONFIG)) begin
        misc_config_reg <= w16;
      end
      if (wr_hit(HSM_CMD_TOOL_SCRATCH)) begin
        tool_scratch_reg <= w16;
      end
      if (wr_hit(HSM_CMD_OEM_SCRATCH)) begin
        oem_scratch_reg <= w16;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_polarity_reg <= HSM_RST_PIN_POLARITY;
      low_out_sel_reg  <= HSM_RST_LOW_OUT_SEL;
      high_out_sel_reg <= HSM_RST_HIGH_OUT_SEL;
      in_sel_reg       <= HSM_RST_IN_SEL;
    end else if (ce_i) begin
      if (wr_hit(HSM_CMD_PIN_POLARITY)) begin
        pin_polarity_reg <= w16;
      end
      if (wr_hit(HSM_CMD_LOW_OUT_SEL)) begin
        low_out_sel_reg <= w16;
      end
      if (wr_hit(HSM_CMD_HIGH_OUT_SEL)) begin
        high_out_sel_reg <= w16;
      end
      if (wr_hit(HSM_CMD_IN_SEL)) begin
        in_sel_reg <= w16;
      end
    end
  end

  // ----------------------------------------------------------------
  // tick timer
  // ----------------------------------------------------------------
  hsm_tick_if tick_bus ();
  // spelled out: nets read inside a function would not wake a continuous assign
  assign tick_bus.load     = wr_i && (cmd_i == HSM_CMD_TICK_TIMER);
  assign tick_bus.load_val = wdata_i;
  hsm_tick_timer u_tick (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .tick_i (tick_i),
    .tk     (tick_bus.timer)
  );

  // ----------------------------------------------------------------
  // pad inputs, polarity applied per pin
  // ----------------------------------------------------------------
  logic [HSM_NPINS-1:0] pad_in_reg;
  // pad state sits in the low byte of the live word
  generate
    for (genvar p = 0; p < HSM_NPINS; p++) begin : g_pad
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pad_in_reg[p] <= 1'b0;
        end else if (ce_i) begin
          pad_in_reg[p] <= pad_live_i[p] ^ pin_polarity_reg[p];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  logic      show_avg;
  hsm_data_t rd_val;
  logic [2:0] rd_len;
  assign show_avg = adc_avg_reg[HSM_AVG_SHOW_BIT];
  // unknown codes answer length zero so the serial engine can refuse them
  always_comb begin
    rd_val = '0;
    rd_len = HSM_LEN_WORD;
    case (cmd_i)
      HSM_CMD_MISC_FAULT:     begin rd_val[7:0]  = misc_fault_reg;   rd_len = HSM_LEN_BYTE; end
      HSM_CMD_VENDOR_FAULT:   begin rd_val[7:0]  = vendor_fault_reg; rd_len = HSM_LEN_BYTE; end
      HSM_CMD_VIN_READ:       rd_val[15:0] = show_avg ? vin_avg_i  : vin_inst_i;
      HSM_CMD_VOUT_READ:      rd_val[15:0] = show_avg ? vout_avg_i : vout_inst_i;
      HSM_CMD_IOUT_READ:      rd_val[15:0] = show_avg ? iout_avg_i : iout_inst_i;
      HSM_CMD_TEMP_READ:      rd_val[15:0] = temp_i;
      HSM_CMD_PIN_READ:       rd_val[15:0] = show_avg ? pin_avg_i  : pin_inst_i;
      HSM_CMD_PROTO_REV:      begin rd_val[7:0]  = HSM_PROTO_REV_1P3; rd_len = HSM_LEN_BYTE; end
      HSM_CMD_MAKER_STRING:   begin rd_val[23:0] = MAKER_STRING; rd_len = HSM_LEN_MAKER; end
      HSM_CMD_HW_REV:         begin rd_val[7:0]  = HW_REVISION;  rd_len = HSM_LEN_BYTE; end
      HSM_CMD_PART_ID:        begin rd_val[7:0]  = PART_ID;      rd_len = HSM_LEN_BYTE; end
      HSM_CMD_PART_REV:       begin rd_val[7:0]  = PART_REV;     rd_len = HSM_LEN_BYTE; end
      HSM_CMD_TOOL_SCRATCH:   rd_val[15:0] = tool_scratch_reg;
      HSM_CMD_OEM_SCRATCH:    rd_val[15:0] = oem_scratch_reg;
      HSM_CMD_FAULT_PIN_OPT:  begin rd_val[7:0] = fault_pin_option_reg; rd_len = HSM_LEN_BYTE; end
      HSM_CMD_FET_BAD_RESP:   begin rd_val[7:0] = fet_bad_response_reg; rd_len = HSM_LEN_BYTE; end
      HSM_CMD_OVERPOWER_RESP: rd_val[15:0] = overpower_response_reg;
      HSM_CMD_ADC_MODE:       begin rd_val[7:0] = adc_mode_reg; rd_len = HSM_LEN_BYTE; end
      HSM_CMD_ADC_AVG:        begin rd_val[7:0] = adc_avg_reg;  rd_len = HSM_LEN_BYTE; end
      HSM_CMD_TICK_TIMER:     begin rd_val = tick_bus.value; rd_len = HSM_LEN_TICK; end
      HSM_CMD_SYS_STATUS:     rd_val[15:0] = sys_status_reg;
      HSM_CMD_SYS_WARNING:    rd_val[15:0] = sys_warning_reg;
      HSM_CMD_BUS_FAIL:       begin rd_val[7:0] = bus_fail_reg; rd_len = HSM_LEN_BYTE; end
      HSM_CMD_PAD_LIVE:       rd_val[15:0] = pad_live_i;
      HSM_CMD_SPECIAL_ID:     rd_val[15:0] = SPECIAL_ID;
      HSM_CMD_FAMILY_STATUS:  begin rd_val[7:0] = family_status_i; rd_len = HSM_LEN_BYTE; end
      HSM_CMD_SD_REASON:      begin rd_val[7:0] = sd_reason_reg;   rd_len = HSM_LEN_BYTE; end
      HSM_CMD_LIMIT_RANGE:    rd_val[15:0] = limit_range_reg;
      HSM_CMD_MISC_CONFIG:    rd_val[15:0] = misc_config_reg;
      HSM_CMD_PIN_POLARITY:   rd_val[15:0] = pin_polarity_reg;
      HSM_CMD_LOW_OUT_SEL:    rd_val[15:0] = low_out_sel_reg;
      HSM_CMD_HIGH_OUT_SEL:   rd_val[15:0] = high_out_sel_reg;
      HSM_CMD_IN_SEL:         rd_val[15:0] = in_sel_reg;
      default:                rd_len = HSM_LEN_NONE;
    endcase
  end
  // read-only codes have no write path above, so a write is dropped
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= '0;
      rlen_o   <= HSM_LEN_NONE;
    end else if (ce_i) begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        rdata_o <= rd_val;
        rlen_o  <= rd_len;
      end
    end
  end
  // ----------------------------------------------------------------
  // settings out
  // ----------------------------------------------------------------
  assign fault_pin_option_o   = fault_pin_option_reg;
  assign fet_bad_response_o   = fet_bad_response_reg;
  assign overpower_response_o = overpower_response_reg;
  assign adc_mode_o           = adc_mode_reg;
  assign adc_avg_o            = adc_avg_reg;
  assign limit_range_o        = limit_range_reg;
  assign misc_config_o        = misc_config_reg;
  assign pin_polarity_o       = pin_polarity_reg;
  assign low_out_sel_o        = low_out_sel_reg;
  assign high_out_sel_o       = high_out_sel_reg;
  assign in_sel_o             = in_sel_reg;
  assign pad_in_o             = pad_in_reg;
endmodule : hsm_command_bank

`default_nettype wire

// file: verif/hsm_command_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module hsm_command_bank_monitor
  import hsm_pkg::*;
(
  input wire logic                 clk_i, nrst_i, ce_i, wr_i, rd_i, rvalid_o,
  input wire logic [7:0]           cmd_i, adc_mode_o, adc_avg_o,
  input wire logic [HSM_NPINS-1:0] pad_in_o,
  input wire logic [2:0]           rlen_o,
  input wire logic [15:0]          vin_avg_i, pad_live_i, limit_range_o, pin_polarity_o,
  input wire hsm_pkg::hsm_data_t   wdata_i, rdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  read_answer_a: assert property (ce_i && rd_i |=> rvalid_o)
    else $error("read not answered");
  read_hold_a: assert property (!(ce_i && rd_i) |=> !rvalid_o && $stable(rdata_o))
    else $error("answer moved without read");
  proto_rev_a: assert property (ce_i && rd_i && cmd_i == 8'h98 |=> rdata_o == 48'h33)
    else $error("protocol revision wrong");
  maker_len_a: assert property (ce_i && rd_i && cmd_i == 8'h99 |=> rlen_o == 3'h3)
    else $error("maker length wrong");
  avg_show_a: assert property (ce_i && rd_i && cmd_i == 8'h88 && adc_avg_o[7]
    |=> rdata_o == {32'h0, $past(vin_avg_i)}) else $error("averaged reading wrong");
  adc_write_a: assert property (ce_i && wr_i && cmd_i == 8'hd8
    |=> adc_mode_o == $past(wdata_i[7:0])) else $error("adc mode not written");
  limit_hold_a: assert property (!(ce_i && wr_i && cmd_i == 8'hf2)
    |=> $stable(limit_range_o)) else $error("limit word moved");
  pad_level_a: assert property (ce_i |=> pad_in_o ==
    ($past(pad_live_i[7:0]) ^ $past(pin_polarity_o[7:0]))) else $error("pad level wrong");
  cover property (ce_i && rd_i && cmd_i == 8'hdc);
  cover property (ce_i && wr_i && cmd_i == 8'hf4);
  cover property (ce_i && rd_i && cmd_i == 8'h88 && adc_avg_o[7]);
endmodule : hsm_command_bank_monitor
bind hsm_command_bank hsm_command_bank_monitor u_hsm_command_bank_monitor (.clk_i, .nrst_i,
  .ce_i, .wr_i, .rd_i, .rvalid_o, .cmd_i, .adc_mode_o, .adc_avg_o, .pad_in_o, .rlen_o,
  .vin_avg_i, .pad_live_i, .limit_range_o, .pin_polarity_o, .wdata_i, .rdata_o);
`default_nettype wire

// file: verif/hsm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hsm_host_model
  import hsm_pkg::*;
(
  input  wire logic         clk_i,
  input  wire hsm_data_t    rdata_i,
  input  wire logic [2:0]   rlen_i,
  output var logic [7:0]    cmd_o,
  output var logic          wr_o, rd_o, send_o,
  output var hsm_data_t     wdata_o
);
  initial {cmd_o, wr_o, rd_o, send_o, wdata_o} = '0;
  // released command and data lines are inverted and the strobes dropped, so a stale value never passes for a request
  task automatic op(input logic [1:0] k, input logic [7:0] c, input hsm_data_t d,
                    output hsm_data_t q, output logic [2:0] n);
    @(negedge clk_i);
    cmd_o = c;
    wdata_o = d;
    {wr_o, rd_o, send_o} = {k == 2'd1, k == 2'd2, k == 2'd3};
    @(negedge clk_i);
    q = rdata_i;
    n = rlen_i;
    {wr_o, rd_o, send_o} = 3'b000;
    cmd_o = ~c;
    wdata_o = ~d;
  endtask : op
endmodule : hsm_host_model
`default_nettype wire

// file: verif/hsm_command_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hsm_command_bank_bench;
  import hsm_pkg::*;
  logic clk_i, nrst_i, ce_i, wr_i, rd_i, send_i, rvalid_o, sd, tk;
  logic [7:0] cmd_i;
  logic [2:0] rlen_o, n;
  logic [15:0] m, ev;
  logic [27:0] e;
  hsm_data_t wdata_i, rdata_o, q;
  logic [95:0] so;
  int n_mismatch = 0, checked = 0, cyc = 0;
  // cmd, writable and length nibble, value; 0x88 sits before 0xd9 to see averaging
  logic [27:0] tbl [26] = '{28'h882edcb, 28'hd290000, 28'hd690041, 28'hd7affe0, 28'hd890001,
    28'hd990085, 28'h8b21235, 28'h8c21236, 28'h9721237, 28'h8d21238, 28'he52486e, 28'hef10012,
    28'h9b10001, 28'he721234, 28'h9810033, 28'hf110000, 28'h7f10000, 28'he120000, 28'hf2a5572,
    28'hf3a00ef, 28'hf4a009b, 28'hf5a5f43, 28'hf6a8207, 28'hf7a0005, 28'hb0a0000, 28'he290000};
  hsm_command_bank u_hsm_command_bank (.clk_i, .nrst_i, .ce_i, .cmd_i, .wr_i, .rd_i, .send_i,
    .wdata_i, .rvalid_o, .rdata_o, .rlen_o, .vin_inst_i(m), .vin_avg_i(~m),
    .vout_inst_i(m + 16'h1), .vout_avg_i(~(m + 16'h1)), .iout_inst_i(m + 16'h2),
    .iout_avg_i(~(m + 16'h2)), .pin_inst_i(m + 16'h3), .pin_avg_i(~(m + 16'h3)),
    .temp_i(m + 16'h4), .misc_fault_set_i(ev[7:0]), .vendor_fault_set_i(ev[15:8]),
    .sys_status_set_i(ev), .sys_warning_set_i(ev), .bus_fail_set_i(ev[7:0]), .shutdown_i(sd),
    .shutdown_cause_i(ev[15:8]), .pad_live_i(m ^ 16'h5a5a), .family_status_i(m[15:8]),
    .tick_i(tk), .fault_pin_option_o(so[7:0]), .fet_bad_response_o(so[15:8]),
    .overpower_response_o(so[31:16]), .adc_mode_o(), .adc_avg_o(), .limit_range_o(),
    .misc_config_o(so[47:32]), .pin_polarity_o(), .low_out_sel_o(so[63:48]),
    .high_out_sel_o(so[79:64]), .in_sel_o(so[95:80]), .pad_in_o());
  hsm_host_model u_hsm_host_model (.clk_i, .rdata_i(rdata_o), .rlen_i(rlen_o), .cmd_o(cmd_i),
    .wr_o(wr_i), .rd_o(rd_i), .send_o(send_i), .wdata_o(wdata_i));
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] c, input logic [2:0] l, input hsm_data_t x);
    u_hsm_host_model.op(2'd2, c, '0, q, n);
    chk({45'h0, n, q}, {45'h0, l, x});
  endtask : rc
  task automatic wr(input logic [7:0] c, input hsm_data_t d);
    u_hsm_host_model.op(2'd1, c, d, q, n);
  endtask : wr
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    {nrst_i, sd, tk, ev} = 19'h0;
    ce_i = 1'b1;
    m = 16'h1234;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i) nrst_i = 1'b1;
    chk(so, 96'h0005_8207_5f43_00ef_ffe0_41_00);
    foreach (tbl[i]) begin
      e = tbl[i];
      rc(e[27:20], e[18:16], {32'h0, e[15:0]});
      wr(e[27:20], {32'h0, ~e[15:0]});
      rc(e[27:20], e[18:16], {32'h0, e[19] ? ~e[15:0] & (e[16] ? 16'h00ff : 16'hffff)
        : e[15:0]});
    end
    rc(8'h99, 3'h3, 48'h414243);
    chk(so, 96'hfffa_7df8_a0bc_ff10_001f_be_ff);
    // a write while the enable is low must not land
    @(negedge clk_i) ce_i = 1'b0;
    wr(8'hd2, 48'h05);
    ce_i = 1'b1;
    rc(8'hd2, 3'h1, 48'hff);
    @(negedge clk_i) {sd, ev} = 17'h10503;
    @(negedge clk_i) {sd, ev} = 17'h0;
    rc(8'h7f, 3'h1, 48'h03);
    wr(8'h7f, 48'h01);
    rc(8'h7f, 3'h1, 48'h02);
    rc(8'h80, 3'h1, 48'h05);
    wr(8'he0, 48'h0002);
    rc(8'he0, 3'h2, 48'h0501);
    rc(8'hf1, 3'h1, 48'h05);
    u_hsm_host_model.op(2'd3, 8'h03, '0, q, n);
    for (int i = 0; i < 6; i++)
      rc(8'(48'h7f80e0e1e2f1 >> (40 - 8 * i)), (i == 2 || i == 3) ? 3'h2 : 3'h1,
        48'h0);
    @(negedge clk_i) tk = 1'b1;
    repeat (3) @(negedge clk_i);
    tk = 1'b0;
    rc(8'hdc, 3'h6, 48'h3);
    wr(8'hdc, 48'h123456789abc);
    rc(8'hdc, 3'h6, 48'h123456789abc);
    end_sim();
  end
endmodule : hsm_command_bank_bench
`default_nettype wire
